/* core/halfword_load_unit.sv */
// halfword load unit: accepts one instruction, reads operands, loads a halfword
// assumes an async-read register file outside and a memory path that answers
// one halfword per request together with its translation result
`timescale 1ns/1ps

// Functional notes
// - op 31 xo 375: sign-extend, indexed, update
// - op 31 xo 343: sign-extend, indexed
// - op 31 xo 790: byte swap, zero-extend
// - op 40: displacement, zero-extend
// - op 41: displacement, zero-extend, update
// - op 31 xo 311: zero-extend, indexed, update
// - immediate sign-extended to 32 bits
// - non-update base zero when field zero
// - indexed adds full index register
// - update uses register base, writes address back
// - sign-extend halfword into 32-bit target
// - zero-extend halfword with 16 zeros
// - swap bytes, clear upper target half
// - storage fault only user, relocation, no-access
// - relocation with no translation gives miss
// - bad update form, no program exception
// - reserved bit set, no program exception
// - only target and base registers written
module halfword_load_unit
    import halfword_load_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  instr_req_t             instr_in,
    output logic                   instr_ready,
    input  wire logic              user_mode,
    input  wire logic              data_reloc,
    output logic [REG_AW-1:0]      gpr_base_addr,
    output logic [REG_AW-1:0]      gpr_idx_addr,
    input  wire logic [XLEN-1:0]   gpr_base_data,
    input  wire logic [XLEN-1:0]   gpr_idx_data,
    output mem_req_t               mem_out,
    input  mem_resp_t              mem_in,
    output wb_t                    wb_tgt,
    output wb_t                    wb_base,
    output status_t                status
);

    state_t            state_reg;
    state_t            state_next;
    dec_t              dec_now;
    dec_t              dec_reg;
    logic              user_reg;
    logic              reloc_reg;
    logic              accept;
    logic [XLEN-1:0]   base_val;
    logic [XLEN-1:0]   offset_val;
    logic [XLEN-1:0]   effective_addr;
    logic [XLEN-1:0]   addr_reg;
    logic [HALF_W-1:0] half_reg;
    logic              fault_dsi;
    logic              fault_tlb;
    wb_t               wb_tgt_reg;
    wb_t               wb_base_reg;
    status_t           status_reg;

    function automatic logic [XLEN-1:0] sign_extend_op(input logic [HALF_W-1:0] h);
        sign_extend_op = {{(XLEN-HALF_W){h[HALF_W-1]}}, h};
    endfunction

    function automatic logic [XLEN-1:0] shape_result(input dec_t d,
                                                     input logic [HALF_W-1:0] h);
        if (d.sext)
            shape_result = sign_extend_op(h);
        else if (d.swap)
            shape_result = {{(XLEN-HALF_W){1'b0}}, h[7:0], h[15:8]};
        else
            shape_result = {{(XLEN-HALF_W){1'b0}}, h};
    endfunction

    halfword_load_decode u_halfword_load_decode
    (
        .word (instr_in.word),
        .dec  (dec_now)
    );

    assign instr_ready = (state_reg == ST_IDLE);
    assign accept      = instr_in.valid && instr_ready;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (accept)
                    state_next = dec_now.legal ? ST_OPND : ST_DONE;
            ST_OPND:
                state_next = ST_MEM;
            ST_MEM:
                if (mem_in.valid)
                    state_next = ST_DONE;
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dec_reg   <= '0;
            user_reg  <= 1'b0;
            reloc_reg <= 1'b0;
        end
        else if (accept)
        begin
            dec_reg   <= dec_now;
            user_reg  <= user_mode;
            reloc_reg <= data_reloc;
        end
    end

    assign gpr_base_addr = dec_reg.base;
    assign gpr_idx_addr  = dec_reg.idx;

    assign base_val = (dec_reg.update || (dec_reg.base != REG_ZERO)) ? gpr_base_data : WORD_ZERO;
    assign offset_val     = dec_reg.indexed ? gpr_idx_data : sign_extend_op(dec_reg.imm);
    assign effective_addr = base_val + offset_val;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            addr_reg <= WORD_ZERO;
        else if (state_reg == ST_OPND)
            addr_reg <= effective_addr;
    end

    // address held steady for the whole wait
    assign mem_out.req  = (state_reg == ST_MEM);
    assign mem_out.addr = addr_reg;

    assign fault_tlb = reloc_reg && mem_in.tlb_miss;
    // no-access only in user mode under relocation
    assign fault_dsi = user_reg && reloc_reg && mem_in.no_access && !mem_in.tlb_miss;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            half_reg <= '0;
        else if ((state_reg == ST_MEM) && mem_in.valid)
            half_reg <= mem_in.rdata;
    end

    // write-back pulses for exactly the done cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_tgt_reg  <= '0;
            wb_base_reg <= '0;
        end
        else if ((state_reg == ST_MEM) && mem_in.valid)
        begin
            wb_tgt_reg.en    <= !fault_tlb && !fault_dsi;
            wb_tgt_reg.addr  <= dec_reg.tgt;
            wb_tgt_reg.data  <= shape_result(dec_reg, mem_in.rdata);
            // base write only for update forms
            // base equal target lets target win
            wb_base_reg.en   <= !fault_tlb && !fault_dsi && dec_reg.update
                                && (dec_reg.base != dec_reg.tgt);
            wb_base_reg.addr <= dec_reg.base;
            wb_base_reg.data <= addr_reg;
        end
        else
        begin
            wb_tgt_reg.en  <= 1'b0;
            wb_base_reg.en <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            status_reg <= '0;
        else if (accept && !dec_now.legal)
        begin
            status_reg             <= '0;
            status_reg.done        <= 1'b1;
            status_reg.unsupported <= 1'b1;
        end
        else if ((state_reg == ST_MEM) && mem_in.valid)
        begin
            status_reg.done         <= 1'b1;
            status_reg.data_storage <= fault_dsi;
            status_reg.tlb_miss     <= fault_tlb;
            status_reg.invalid_form <= dec_reg.invalid_form;
            status_reg.unsupported  <= 1'b0;
        end
        else
            status_reg.done <= 1'b0;
    end

    assign wb_tgt  = wb_tgt_reg;
    assign wb_base = wb_base_reg;
    assign status  = status_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_decode_sext_up;
        accept && (instr_in.word[31:26] == 6'h1F) && (instr_in.word[10:1] == 10'h177)
        |=> dec_reg.sext && dec_reg.update && dec_reg.indexed && (state_reg == ST_OPND);
    endproperty
    a_decode_sext_up: assert property (p_decode_sext_up)
        else $error("sign-extend update indexed form not decoded");

    property p_decode_swap;
        accept && (instr_in.word[31:26] == 6'h1F) && (instr_in.word[10:1] == 10'h316)
        |=> dec_reg.swap && !dec_reg.update && !dec_reg.sext;
    endproperty
    a_decode_swap: assert property (p_decode_swap)
        else $error("byte swap form not decoded");

    property p_disp_zero_base;
        (state_reg == ST_OPND) && !dec_reg.indexed && !dec_reg.update
        && (dec_reg.base == 5'h00)
        |=> addr_reg == {{16{$past(dec_reg.imm[15])}}, $past(dec_reg.imm)};
    endproperty
    a_disp_zero_base: assert property (p_disp_zero_base)
        else $error("displacement address with zero base wrong");

    property p_index_sum;
        (state_reg == ST_OPND) && dec_reg.indexed && (dec_reg.base != 5'h00)
        |=> addr_reg == $past(gpr_base_data) + $past(gpr_idx_data);
    endproperty
    a_index_sum: assert property (p_index_sum)
        else $error("indexed address is not base plus index");

    property p_sext_result;
        (state_reg == ST_MEM) && mem_in.valid && dec_reg.sext && !fault_tlb && !fault_dsi
        |=> wb_tgt.en && (wb_tgt.data == {{16{$past(mem_in.rdata[15])}}, $past(mem_in.rdata)});
    endproperty
    a_sext_result: assert property (p_sext_result)
        else $error("sign-extended result wrong");

    property p_swap_result;
        wb_tgt.en && dec_reg.swap
        |-> wb_tgt.data == {16'h0000, half_reg[7:0], half_reg[15:8]};
    endproperty
    a_swap_result: assert property (p_swap_result)
        else $error("byte swapped result wrong");

    property p_base_update;
        wb_base.en |-> dec_reg.update && (wb_base.data == addr_reg)
                       && (wb_base.addr == dec_reg.base) && status.done;
    endproperty
    a_base_update: assert property (p_base_update)
        else $error("base write-back wrong");

    property p_only_update_writes_base;
        (state_reg == ST_DONE) && !dec_reg.update |-> !wb_base.en;
    endproperty
    a_only_update_writes_base: assert property (p_only_update_writes_base)
        else $error("non-update form wrote base");

    property p_dsi_cause;
        status.done && status.data_storage |-> user_reg && reloc_reg;
    endproperty
    a_dsi_cause: assert property (p_dsi_cause)
        else $error("storage fault outside user relocated mode");

    property p_tlb_raise;
        (state_reg == ST_MEM) && mem_in.valid && reloc_reg && mem_in.tlb_miss
        |=> status.done && status.tlb_miss;
    endproperty
    a_tlb_raise: assert property (p_tlb_raise)
        else $error("translation miss not raised");

    property p_fault_no_write;
        status.done && (status.data_storage || status.tlb_miss) |-> !wb_tgt.en && !wb_base.en;
    endproperty
    a_fault_no_write: assert property (p_fault_no_write)
        else $error("faulting load wrote a register");

    property p_invalid_runs;
        (state_reg == ST_MEM) && mem_in.valid && dec_reg.invalid_form && !fault_tlb && !fault_dsi
        |=> status.invalid_form && !status.unsupported && wb_tgt.en;
    endproperty
    a_invalid_runs: assert property (p_invalid_runs)
        else $error("invalid form trapped instead of executed");

    c_swap_load:   cover property (wb_tgt.en && dec_reg.swap);
    c_update_load: cover property (wb_base.en && dec_reg.indexed);
    c_dsi:         cover property (status.done && status.data_storage);
    c_tlb:         cover property (status.done && status.tlb_miss);

endmodule // halfword_load_unit

/* core/halfword_load_pkg.sv */
// halfword load unit: shared constants, field positions, states and carriers
// assumes little-endian instruction bit numbering (bit 31 is the msb)
package halfword_load_pkg;

    localparam int XLEN         = 32;
    localparam int HALF_W       = 16;
    localparam int REG_AW       = 5;

    // instruction field positions, little-endian index of msb/lsb
    localparam int F_PRIM_HI    = 31;
    localparam int F_PRIM_LO    = 26;
    localparam int F_TGT_HI     = 25;
    localparam int F_TGT_LO     = 21;
    localparam int F_BASE_HI    = 20;
    localparam int F_BASE_LO    = 16;
    localparam int F_IDX_HI     = 15;
    localparam int F_IDX_LO     = 11;
    localparam int F_XO_HI      = 10;
    localparam int F_XO_LO      = 1;
    localparam int F_RSVD       = 0;
    localparam int F_IMM_HI     = 15;

    localparam logic [5:0] OP_INDEXED      = 6'h1F;
    localparam logic [5:0] OP_ZEXT_DISP    = 6'h28;
    localparam logic [5:0] OP_ZEXT_DISP_UP = 6'h29;

    localparam logic [9:0] XO_SEXT_IDX_UP  = 10'h177;
    localparam logic [9:0] XO_SEXT_IDX     = 10'h157;
    localparam logic [9:0] XO_SWAP_IDX     = 10'h316;
    localparam logic [9:0] XO_ZEXT_IDX_UP  = 10'h137;

    localparam logic [REG_AW-1:0] REG_ZERO = 5'h00;
    localparam logic [XLEN-1:0]   WORD_ZERO = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPND = 4'b0010,
        ST_MEM  = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;

    typedef struct packed {
        logic              legal;
        logic              indexed;
        logic              update;
        logic              sext;
        logic              swap;
        logic              invalid_form;
        logic [REG_AW-1:0] tgt;
        logic [REG_AW-1:0] base;
        logic [REG_AW-1:0] idx;
        logic [HALF_W-1:0] imm;
    } dec_t;

    typedef struct packed {
        logic            valid;
        logic [XLEN-1:0] word;
    } instr_req_t;

    typedef struct packed {
        logic            req;
        logic [XLEN-1:0] addr;
    } mem_req_t;

    typedef struct packed {
        logic              valid;
        logic [HALF_W-1:0] rdata;
        logic              no_access;
        logic              tlb_miss;
    } mem_resp_t;

    typedef struct packed {
        logic              en;
        logic [REG_AW-1:0] addr;
        logic [XLEN-1:0]   data;
    } wb_t;

    typedef struct packed {
        logic done;
        logic data_storage;
        logic tlb_miss;
        logic invalid_form;
        logic unsupported;
    } status_t;

endpackage

/* core/halfword_load_decode.sv */
// halfword load unit: combinational instruction decoder
// assumes a 32-bit instruction word with bit 31 as msb in the listed fields
`timescale 1ns/1ps
module halfword_load_decode
    import halfword_load_pkg::*;
(
    input  wire logic [XLEN-1:0] word,
    output dec_t                 dec
);

    logic [5:0] prim;
    logic [9:0] xo;
    logic       x_sext_up;
    logic       x_sext;
    logic       x_swap;
    logic       x_zext_up;
    logic       d_zext;
    logic       d_zext_up;

    assign prim = word[F_PRIM_HI:F_PRIM_LO];
    assign xo   = word[F_XO_HI:F_XO_LO];

    assign x_sext_up = (prim == OP_INDEXED) && (xo == XO_SEXT_IDX_UP);
    assign x_sext    = (prim == OP_INDEXED) && (xo == XO_SEXT_IDX);
    assign x_swap    = (prim == OP_INDEXED) && (xo == XO_SWAP_IDX);
    assign x_zext_up = (prim == OP_INDEXED) && (xo == XO_ZEXT_IDX_UP);
    assign d_zext    = (prim == OP_ZEXT_DISP);
    assign d_zext_up = (prim == OP_ZEXT_DISP_UP);

    always_comb
    begin
        dec.tgt     = word[F_TGT_HI:F_TGT_LO];
        dec.base    = word[F_BASE_HI:F_BASE_LO];
        dec.idx     = word[F_IDX_HI:F_IDX_LO];
        dec.imm     = word[F_IMM_HI:0];
        dec.indexed = x_sext_up | x_sext | x_swap | x_zext_up;
        dec.legal   = dec.indexed | d_zext | d_zext_up;
        dec.update  = x_sext_up | x_zext_up | d_zext_up;
        dec.sext    = x_sext_up | x_sext;
        dec.swap    = x_swap;
        // reserved bit set in indexed form, or update form with base equal to target or base zero
        dec.invalid_form = (dec.indexed && word[F_RSVD])
                         || (dec.update && ((dec.base == dec.tgt) || (dec.base == REG_ZERO)));
    end

endmodule // halfword_load_decode

/* verification/halfword_mem_model.sv */
// data memory path and translation model for the halfword load unit
// assumes one request at a time, answered after wait_cycles idle edges
`timescale 1ns/1ps
module halfword_mem_model
    import halfword_load_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  mem_req_t        mem_out,
    input  wire logic [3:0] wait_cycles,
    input  wire logic       zone_na,
    input  wire logic       tlb_absent,
    output mem_resp_t       mem_in
);
    logic [3:0] cnt_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_reg <= 4'h0;
            mem_in  <= '0;
        end
        else if (mem_out.req && !mem_in.valid && cnt_reg == wait_cycles)
        begin
            // byte at the address rides the upper lane
            mem_in.valid     <= 1'b1;
            mem_in.rdata     <= mem_out.addr[15:0] ^ {mem_out.addr[23:16], mem_out.addr[31:24]};
            mem_in.no_access <= zone_na;
            mem_in.tlb_miss  <= tlb_absent;
        end
        else
        begin
            // stale answer flips each cycle so it never passes for data
            cnt_reg          <= (mem_out.req && !mem_in.valid) ? cnt_reg + 4'h1 : 4'h0;
            mem_in.valid     <= 1'b0;
            mem_in.rdata     <= ~mem_in.rdata;
            mem_in.no_access <= ~mem_in.no_access;
            mem_in.tlb_miss  <= ~mem_in.tlb_miss;
        end
    end
endmodule // halfword_mem_model

/* verification/halfword_load_unit_bench.sv */
// self-checking bench for the halfword load unit
// assumes the memory model beside it; register file is a static table here
`timescale 1ns/1ps
module halfword_load_unit_bench
    import halfword_load_pkg::*;
();
    typedef struct packed {
        wb_t     t;
        wb_t     b;
        status_t s;
    } note_t;

    logic        clk;
    logic        nrst;
    instr_req_t  instr_in;
    logic        instr_ready;
    logic        user_mode;
    logic        data_reloc;
    logic [4:0]  gpr_base_addr;
    logic [4:0]  gpr_idx_addr;
    logic [31:0] gpr_base_data;
    logic [31:0] gpr_idx_data;
    mem_req_t    mem_out;
    mem_resp_t   mem_in;
    wb_t         wb_tgt;
    wb_t         wb_base;
    status_t     status;
    logic [3:0]  wait_cycles;
    logic        zone_na;
    logic        tlb_absent;
    logic [31:0] gpr [32];
    logic [15:0] op_tab [8];
    logic [31:0] seed;
    note_t       q_note [$];
    logic [31:0] q_addr [$];
    int          n_fail;
    int          checked;
    int          n_done;

    assign gpr_base_data = gpr[gpr_base_addr];
    assign gpr_idx_data  = gpr[gpr_idx_addr];

    halfword_load_unit u_halfword_load_unit (.clk(clk), .nrst(nrst), .instr_in(instr_in),
        .instr_ready(instr_ready), .user_mode(user_mode), .data_reloc(data_reloc),
        .gpr_base_addr(gpr_base_addr), .gpr_idx_addr(gpr_idx_addr),
        .gpr_base_data(gpr_base_data), .gpr_idx_data(gpr_idx_data), .mem_out(mem_out),
        .mem_in(mem_in), .wb_tgt(wb_tgt), .wb_base(wb_base), .status(status));

    halfword_mem_model u_halfword_mem_model (.clk(clk), .nrst(nrst), .mem_out(mem_out),
        .wait_cycles(wait_cycles), .zone_na(zone_na), .tlb_absent(tlb_absent),
        .mem_in(mem_in));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin : mon
        note_t n;
        if (nrst === 1'b1 && mem_in.valid === 1'b1 && mem_out.req === 1'b1)
        begin
            if (q_addr.size() == 0)
                check(64'h1, 64'h0);
            else
                check(mem_out.addr, q_addr.pop_front());
        end
        if (status.done === 1'b1)
        begin
            n = q_note.size() ? q_note.pop_front() : '0;
            check(status, n.s);
            check(wb_tgt.en, n.t.en);
            if (n.t.en)
                check(wb_tgt, n.t);
            check(wb_base.en, n.b.en);
            if (n.b.en)
                check(wb_base, n.b);
            n_done++;
        end
        else if (nrst === 1'b1)
            check({wb_tgt.en, wb_base.en}, 64'h0);
    end

    task automatic issue(input logic [31:0] w, input logic um, input logic rl,
                         input logic na, input logic miss);
        logic [9:0]  xo;
        logic [4:0]  t;
        logic [4:0]  b;
        logic        idx;
        logic        ok;
        logic        up;
        logic        sx;
        logic        flt;
        logic [31:0] eff;
        logic [15:0] h;
        note_t       n;
        int          k;
        int          goal;
        xo   = w[10:1];
        t    = w[25:21];
        b    = w[20:16];
        goal = n_done + 1;
        idx = w[31:26] == 6'h1F;
        ok  = w[31:26] == 6'h28 || w[31:26] == 6'h29 ||
              (idx && (xo == 10'h177 || xo == 10'h157 || xo == 10'h316 || xo == 10'h137));
        up  = w[31:26] == 6'h29 || (idx && (xo == 10'h177 || xo == 10'h137));
        sx  = idx && (xo == 10'h177 || xo == 10'h157);
        eff = ((up || b != 5'h00) ? gpr[b] : 32'h0) +
              (idx ? gpr[w[15:11]] : {{16{w[15]}}, w[15:0]});
        h   = eff[15:0] ^ {eff[23:16], eff[31:24]};
        n   = '0;
        n.s.done = 1'b1;
        n.s.unsupported = !ok;
        if (ok)
        begin
            q_addr.push_back(eff);
            n.s.tlb_miss     = rl && miss;
            n.s.data_storage = !(rl && miss) && um && rl && na;
            flt = n.s.tlb_miss || n.s.data_storage;
            n.s.invalid_form = (up && (b == t || b == 5'h00)) || (idx && w[0]);
            n.t = '{en: !flt, addr: t, data: 32'h0};
            n.t.data = (idx && xo == 10'h316) ? {16'h0000, h[7:0], h[15:8]} :
                       sx ? {{16{h[15]}}, h} : {16'h0000, h};
            n.b = '{en: !flt && up && b != t, addr: b, data: eff};
        end
        q_note.push_back(n);
        user_mode  <= um;
        data_reloc <= rl;
        zone_na    <= na;
        tlb_absent <= miss;
        instr_in   <= '{valid: 1'b1, word: w};
        k = 0;
        @(posedge clk);
        while (instr_ready !== 1'b1 && k < 20)
        begin
            k++;
            @(posedge clk);
        end
        // modes flip after accept: unit must hold its own copy
        instr_in.valid <= 1'b0;
        user_mode      <= ~um;
        data_reloc     <= ~rl;
        while (n_done < goal && k < 60)
        begin
            k++;
            @(posedge clk);
        end
        if (n_done < goal)
        begin
            check(64'h1, 64'h0);
            close_out();
        end
    endtask

    initial
    begin : main
        logic [31:0] r;
        logic [31:0] w;
        int          i;
        nrst = 1'b0;
        instr_in = '0;
        user_mode = 1'b0;
        data_reloc = 1'b0;
        wait_cycles = 4'h0;
        zone_na = 1'b0;
        tlb_absent = 1'b0;
        n_fail = 0;
        checked = 0;
        n_done = 0;
        seed = 32'h000034F6;
        op_tab = '{16'h7D77, 16'h7D57, 16'h7F16, 16'hA000, 16'hA400, 16'h7D37,
                   16'h7D17, 16'hA800};
        for (i = 0; i < 32; i++)
            gpr[i] = next_rand();
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 160; i++)
        begin
            r = next_rand();
            w = next_rand();
            w[31:26] = op_tab[i % 8][15:10];
            if (w[31:26] == 6'h1F)
                w[10:0] = {op_tab[i % 8][9:0], r[1:0] == 2'b00};
            if (i % 3 == 0)
                w[20:16] = 5'h00;
            if (i % 5 == 0)
                w[20:16] = w[25:21];
            wait_cycles <= {2'b00, r[3:2]};
            issue(w, r[4], r[5], r[6] & r[7], r[8] & r[9]);
        end
        nrst <= 1'b0;
        @(posedge clk);
        check(instr_ready, 64'h1);
        check({mem_out.req, status}, 64'h0);
        nrst <= 1'b1;
        issue(32'hA0A30004, 1'b1, 1'b1, 1'b0, 1'b0);
        close_out();
    end
endmodule // halfword_load_unit_bench
